//--- stc_pkg.sv
// constants, field layout and register map of the 16-bit timer/counter
// assumes an AHB-Lite slave on hclk with 32-bit data and word registers
`default_nettype none

package stc_pkg;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [7:0] STC_OFS_CTRL = 8'h00;
    localparam logic [7:0] STC_OFS_LOW = 8'h04;
    localparam logic [7:0] STC_OFS_HIGH = 8'h08;
    localparam logic [7:0] STC_OFS_STAT = 8'h0c;
    localparam logic [7:0] STC_OFS_MASK = 8'h10;
    localparam logic [7:0] STC_OFS_AUX = 8'h14;

    // ************************************************************
    // control fields and reset values
    // ************************************************************
    localparam int STC_B_WIDE = 7;
    localparam int STC_B_ROUTE_HI = 6;
    localparam int STC_B_PS_HI = 5;
    localparam int STC_B_PS_LO = 4;
    localparam int STC_B_ROUTE_LO = 3;
    localparam int STC_B_SYNC_N = 2;
    localparam int STC_B_CS = 1;
    localparam int STC_B_RUN = 0;
    localparam int STC_B_OVF = 0;
    localparam int STC_B_OSC_EN = 0;
    localparam logic [7:0] STC_CTRL_RST = 8'h00;
    localparam logic [15:0] STC_CNT_RST = 16'h0000;
    localparam logic [15:0] STC_CNT_MAX = 16'hffff;

    // ************************************************************
    // timing: internal count clock is the bus clock divided by four
    // ************************************************************
    localparam int STC_INT_DIV = 4;
    localparam logic [1:0] STC_DIV_LAST = 2'(STC_INT_DIV - 1);

endpackage : stc_pkg

`default_nettype wire

//--- stc_timer.sv
// 16-bit up timer/counter with an AHB-Lite register slave
// assumes triggers come from logic on hclk; clock pins are asynchronous
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`default_nettype none

module stc_timer
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic external_clock_pin,
    input wire logic companion_osc_clk,
    input wire logic capture_compare_a_trig,
    input wire logic enhanced_capture_compare_trig,
    output logic timebase_for_capture_compare_a,
    output logic timebase_for_enhanced_capture_compare,
    output logic irq
);
    import stc_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [15:0] cnt;
        logic [7:0] hbuf;
        logic ovf;
        logic mask;
        logic osc_en;
        logic [2:0] pre;
        logic [1:0] div;
        logic p1;
        logic p2;
        logic o1;
        logic o2;
        logic s3;
        logic armed;
        logic pend;
        logic wr_pend;
        logic rd_pend;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic ready;
        logic tb_a;
        logic tb_e;
        logic irq;
    } stc_state_s;

    stc_state_s st_reg;
    stc_state_s st_next;

    function automatic logic [2:0] stc_pre_last(input logic [1:0] ps);
        stc_pre_last = 3'((4'h1 << ps) - 4'h1);
    endfunction : stc_pre_last

    logic run;
    logic ext_sel;
    logic wide;
    logic int_tick;
    logic ext_lvl;
    logic ext_rise;
    logic ext_fall;
    logic src_tick;
    logic pre_tick;
    logic trig;
    logic addr_ok;
    logic wr_low;
    logic wr_high;
    logic [7:0] wbyte;

    always_comb
    begin
        run = st_reg.ctrl[STC_B_RUN];
        ext_sel = st_reg.ctrl[STC_B_CS];
        wide = st_reg.ctrl[STC_B_WIDE];
        int_tick = (st_reg.div == STC_DIV_LAST);
        ext_lvl = st_reg.osc_en ? st_reg.o2 : st_reg.p2;
        ext_rise = ext_lvl && !st_reg.s3;
        ext_fall = !ext_lvl && st_reg.s3;
        wbyte = hwdata[7:0];
        wr_low = st_reg.wr_pend && (st_reg.addr == STC_OFS_LOW);
        wr_high = st_reg.wr_pend && (st_reg.addr == STC_OFS_HIGH);
        // only the module using this timer as time base may reset it
        trig = (capture_compare_a_trig && st_reg.tb_a)
            || (enhanced_capture_compare_trig && st_reg.tb_e);
        addr_ok = hsel && htrans[1] && hready;
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.div = st_reg.div + 2'h1;

        // ************************************************************
        // clock source and synchroniser
        // ************************************************************
        // each source gets its own two flops; the mux only sees synced levels
        st_next.p1 = external_clock_pin;
        st_next.p2 = st_reg.p1;
        st_next.o1 = companion_osc_clk;
        st_next.o2 = st_reg.o1;
        st_next.s3 = ext_lvl;
        if (!run || !ext_sel)
        begin
            st_next.armed = 1'b0;
            st_next.pend = 1'b0;
        end
        else if (ext_fall)
        begin
            st_next.armed = 1'b1;
        end
        src_tick = !ext_sel && int_tick;
        if (ext_sel && st_reg.ctrl[STC_B_SYNC_N])
        begin
            src_tick = ext_rise && st_reg.armed;
        end
        else if (ext_sel)
        begin
            // synced path releases the edge on the internal phase, so it
            // cannot count faster than clk/4
            if (ext_rise && st_reg.armed)
            begin
                st_next.pend = 1'b1;
            end
            if (int_tick && (st_reg.pend || (ext_rise && st_reg.armed)))
            begin
                src_tick = 1'b1;
                st_next.pend = 1'b0;
            end
        end

        // ************************************************************
        // prescaler and counter
        // ************************************************************
        pre_tick = 1'b0;
        if (!run)
        begin
            st_next.pre = 3'h0;
        end
        else if (src_tick)
        begin
            if (st_reg.pre >= stc_pre_last(st_reg.ctrl[STC_B_PS_HI:STC_B_PS_LO]))
            begin
                pre_tick = 1'b1;
                st_next.pre = 3'h0;
            end
            else
            begin
                st_next.pre = st_reg.pre + 3'h1;
            end
        end
        if (trig)
        begin
            st_next.cnt = STC_CNT_RST;
            st_next.pre = 3'h0;
        end
        else if (wr_low)
        begin
            // wide mode writes both halves at once from the buffer
            if (wide)
            begin
                st_next.cnt = {st_reg.hbuf, wbyte};
            end
            else
            begin
                st_next.cnt[7:0] = wbyte;
            end
            st_next.pre = 3'h0;
        end
        else if (wr_high)
        begin
            if (wide)
            begin
                st_next.hbuf = wbyte;
            end
            else
            begin
                st_next.cnt[15:8] = wbyte;
                st_next.pre = 3'h0;
            end
        end
        else if (run && pre_tick)
        begin
            st_next.cnt = st_reg.cnt + 16'h0001;
        end

        // ************************************************************
        // interrupt flag, set wins over clear
        // ************************************************************
        if (st_reg.wr_pend && (st_reg.addr == STC_OFS_STAT) && hwdata[STC_B_OVF])
        begin
            st_next.ovf = 1'b0;
        end
        if (!trig && !wr_low && !wr_high && run && pre_tick && (st_reg.cnt == STC_CNT_MAX))
        begin
            st_next.ovf = 1'b1;
        end

        // ************************************************************
        // other register writes
        // ************************************************************
        if (st_reg.wr_pend)
        begin
            case (st_reg.addr)
                STC_OFS_CTRL: st_next.ctrl = wbyte;
                STC_OFS_MASK: st_next.mask = hwdata[STC_B_OVF];
                STC_OFS_AUX: st_next.osc_en = hwdata[STC_B_OSC_EN];
                default: st_next.ctrl = st_reg.ctrl;
            endcase
        end

        // ************************************************************
        // bus: writes zero wait, reads one wait so a prior write is seen
        // ************************************************************
        st_next.wr_pend = 1'b0;
        if (st_reg.rd_pend)
        begin
            st_next.rd_pend = 1'b0;
            st_next.ready = 1'b1;
            case (st_reg.addr)
                STC_OFS_CTRL: st_next.rdata = {24'h0, st_reg.ctrl};
                STC_OFS_LOW:
                begin
                    st_next.rdata = {24'h0, st_reg.cnt[7:0]};
                    if (wide)
                    begin
                        st_next.hbuf = st_reg.cnt[15:8];
                    end
                end
                STC_OFS_HIGH: st_next.rdata = {24'h0, wide ? st_reg.hbuf : st_reg.cnt[15:8]};
                STC_OFS_STAT: st_next.rdata = {31'h0, st_reg.ovf};
                STC_OFS_MASK: st_next.rdata = {31'h0, st_reg.mask};
                STC_OFS_AUX: st_next.rdata = {31'h0, st_reg.osc_en};
                default: st_next.rdata = 32'h0;
            endcase
        end
        else if (addr_ok)
        begin
            st_next.addr = {haddr[7:2], 2'b00};
            if (hwrite)
            begin
                st_next.wr_pend = 1'b1;
            end
            else
            begin
                st_next.rd_pend = 1'b1;
                st_next.ready = 1'b0;
            end
        end

        st_next.tb_a = st_next.ctrl[STC_B_ROUTE_HI];
        st_next.tb_e = st_next.ctrl[STC_B_ROUTE_HI] || st_next.ctrl[STC_B_ROUTE_LO];
        st_next.irq = st_next.ovf && st_next.mask;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg <= '0;
            st_reg.ctrl <= STC_CTRL_RST;
            st_reg.cnt <= STC_CNT_RST;
            st_reg.ready <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    always_comb
    begin
        hrdata = st_reg.rdata;
        hreadyout = st_reg.ready;
        hresp = 1'b0;
        timebase_for_capture_compare_a = st_reg.tb_a;
        timebase_for_enhanced_capture_compare = st_reg.tb_e;
        irq = st_reg.irq;
    end

    // ************************************************************
    // checks
    // ************************************************************
    wire logic no_load = !trig && !wr_low && !wr_high;
    wire logic inc_now = no_load && run && pre_tick;

    sequence s_wrap;
        inc_now && (st_reg.cnt == STC_CNT_MAX);
    endsequence

    sequence s_flag_up;
        ##1 st_reg.ovf && (st_reg.cnt == STC_CNT_RST);
    endsequence

    property p_wrap_flag;
        @(posedge hclk) disable iff (!hresetn)
        s_wrap |-> s_flag_up;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

    property p_flag_sticky;
        @(posedge hclk) disable iff (!hresetn)
        st_reg.ovf && !(st_reg.wr_pend && st_reg.addr == STC_OFS_STAT) |=> st_reg.ovf;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_trig_clear;
        @(posedge hclk) disable iff (!hresetn)
        trig |=> st_reg.cnt == STC_CNT_RST;
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger did not zero");

    property p_hold_off;
        @(posedge hclk) disable iff (!hresetn)
        !run && no_load |=> $stable(st_reg.cnt);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("count moved while off");

    property p_increment;
        @(posedge hclk) disable iff (!hresetn)
        inc_now |=> st_reg.cnt == 16'($past(st_reg.cnt) + 16'h0001);
    endproperty
    a_increment: assert property (p_increment) else $error("bad increment");

    property p_div_one;
        @(posedge hclk) disable iff (!hresetn)
        run && !ext_sel && (st_reg.ctrl[STC_B_PS_HI:STC_B_PS_LO] == 2'b00) && int_tick
            && no_load |=> st_reg.cnt != $past(st_reg.cnt);
    endproperty
    a_div_one: assert property (p_div_one) else $error("1:1 missed a tick");

    property p_low_latch;
        @(posedge hclk) disable iff (!hresetn)
        st_reg.rd_pend && wide && (st_reg.addr == STC_OFS_LOW)
            |=> st_reg.hbuf == $past(st_reg.cnt[15:8]) ##1 hreadyout;
    endproperty
    a_low_latch: assert property (p_low_latch) else $error("high byte not latched");

    property p_route;
        @(posedge hclk) disable iff (!hresetn)
        st_reg.wr_pend && (st_reg.addr == STC_OFS_CTRL)
            |=> timebase_for_capture_compare_a == $past(hwdata[STC_B_ROUTE_HI])
            && timebase_for_enhanced_capture_compare
            == ($past(hwdata[STC_B_ROUTE_HI]) || $past(hwdata[STC_B_ROUTE_LO]));
    endproperty
    a_route: assert property (p_route) else $error("time base route wrong");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        irq == (st_reg.ovf && st_reg.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("irq does not follow flag");

    property p_int_ignores_pin;
        @(posedge hclk) disable iff (!hresetn)
        run && !ext_sel && !int_tick && no_load |=> $stable(st_reg.cnt);
    endproperty
    a_int_ignores_pin: assert property (p_int_ignores_pin) else $error("pin counted");
endmodule : stc_timer

`default_nettype wire

//--- stc_far_model.sv
// far-side model: capture/compare trigger sources and the two external clocks
// assumes the bench's hclk; clock lines idle high between bursts
`default_nettype none

module stc_far_model
(
    input wire logic hclk,
    output logic ext_pin,
    output logic osc_clk,
    output logic trig_a,
    output logic trig_e
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        ext_pin = 1'b1;
        osc_clk = 1'b1;
        trig_a = 1'b0;
        trig_e = 1'b0;
    end

    // one-cycle pulse, hclk domain
    task automatic trig(input logic sel_e);
        @(posedge hclk);
        trig_a <= !sel_e;
        trig_e <= sel_e;
        @(posedge hclk);
        trig_a <= 1'b0;
        trig_e <= 1'b0;
    endtask : trig

    // n pulses, fall first so each rise is a count; half >= 3 keeps pulses wide
    task automatic burst(input int n, input logic use_osc, input int half);
        repeat (n)
        begin
            repeat (half) @(posedge hclk);
            if (use_osc) osc_clk <= 1'b0; else ext_pin <= 1'b0;
            repeat (half) @(posedge hclk);
            if (use_osc) osc_clk <= 1'b1; else ext_pin <= 1'b1;
        end
    endtask : burst
endmodule : stc_far_model

`default_nettype wire

//--- stc_timer_tb.sv
// self-checking bench for the 16-bit timer/counter
// assumes stc_pkg, stc_timer and stc_far_model are compiled first
`default_nettype none

module stc_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import stc_pkg::*;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, tb_a, tb_e;
    logic ext_pin, osc_clk, trig_a, trig_e;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    int n_errors, tests_run;

    assign hready = hreadyout;

    stc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .external_clock_pin(ext_pin),
        .companion_osc_clk(osc_clk), .capture_compare_a_trig(trig_a),
        .enhanced_capture_compare_trig(trig_e), .timebase_for_capture_compare_a(tb_a),
        .timebase_for_enhanced_capture_compare(tb_e), .irq(irq));

    stc_far_model far (.hclk(hclk), .ext_pin(ext_pin), .osc_clk(osc_clk),
        .trig_a(trig_a), .trig_e(trig_e));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // bounded wait for hready; a hang ends the run
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 20; i++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_errors++;
            $display("[ERR] hreadyout expected 1 seen 0");
            tally_and_finish();
        end
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, {24'h0, d}, q);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask : rdc

    task automatic set_count(input logic [7:0] hi, input logic [7:0] lo);
        wr(STC_OFS_HIGH, hi);
        wr(STC_OFS_LOW, lo);
    endtask : set_count

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rdc("ctrl", STC_OFS_CTRL, 32'h0);
        rdc("high", STC_OFS_HIGH, 32'h0);
        check("irq", 32'(irq), 32'h0);
        check("hresp", 32'(hresp), 32'h0);
        wr(8'h40, 8'hff);
        rdc("unmapped", 8'h40, 32'h0);
        set_count(8'ha5, 8'h5a);
        rdc("low", STC_OFS_LOW, 32'h5a);
        rdc("high", STC_OFS_HIGH, 32'ha5);
        $display("test reset and bytes done");
    endtask : t_reset

    task automatic t_wide();
        wr(STC_OFS_CTRL, 8'h80);
        set_count(8'h77, 8'h88);
        rdc("wide low", STC_OFS_LOW, 32'h88);
        rdc("wide high", STC_OFS_HIGH, 32'h77);
        wr(STC_OFS_HIGH, 8'h11);
        wr(STC_OFS_CTRL, 8'h00);
        rdc("byte high", STC_OFS_HIGH, 32'h77);
        $display("test wide access done");
    endtask : t_wide

    task automatic t_route();
        logic [1:0] c;
        for (int k = 0; k < 4; k++)
        begin
            c = 2'(k);
            wr(STC_OFS_CTRL, {1'b0, c[1], 2'b00, c[0], 3'b000});
            repeat (2) @(posedge hclk);
            check("tb_a", 32'(tb_a), 32'(c[1]));
            check("tb_e", 32'(tb_e), 32'(c[1] | c[0]));
            for (int s = 0; s < 2; s++)
            begin
                set_count(8'h12, 8'h34);
                far.trig(s[0]);
                repeat (2) @(posedge hclk);
                rdc("trig", STC_OFS_LOW, (s == 0 ? c[1] : |c) ? 32'h0 : 32'h34);
            end
        end
        $display("test route and trigger done");
    endtask : t_route

    task automatic t_ovf();
        logic [31:0] q;
        wr(STC_OFS_CTRL, 8'h00);
        wr(STC_OFS_MASK, 8'h00);
        set_count(8'hff, 8'hfe);
        wr(STC_OFS_CTRL, 8'h01);
        repeat (20) @(posedge hclk);
        rdc("flag", STC_OFS_STAT, 32'h1);
        check("masked irq", 32'(irq), 32'h0);
        wr(STC_OFS_MASK, 8'h01);
        repeat (2) @(posedge hclk);
        check("irq", 32'(irq), 32'h1);
        wr(STC_OFS_CTRL, 8'h00);
        rdc("wrapped", STC_OFS_HIGH, 32'h0);
        bus(1'b0, STC_OFS_LOW, 32'h0, q);
        repeat (20) @(posedge hclk);
        rdc("hold", STC_OFS_LOW, q);
        rdc("sticky", STC_OFS_STAT, 32'h1);
        wr(STC_OFS_STAT, 8'h01);
        rdc("cleared", STC_OFS_STAT, 32'h0);
        check("irq off", 32'(irq), 32'h0);
        $display("test overflow done");
    endtask : t_ovf

    // 256 hclk cycles (64 ticks of clk/4) at each division; one count of slack for bus overhead
    task automatic t_presc();
        logic [31:0] q;
        int d;
        for (int ps = 0; ps < 4; ps++)
        begin
            set_count(8'h00, 8'h00);
            wr(STC_OFS_CTRL, {2'b00, 2'(ps), 4'b0001});
            repeat (256) @(posedge hclk);
            wr(STC_OFS_CTRL, 8'h00);
            bus(1'b0, STC_OFS_LOW, 32'h0, q);
            d = int'(q) - (64 >> ps);
            check("prescale", 32'(d >= -1 && d <= 1), 32'h1);
        end
        $display("test prescale done");
    endtask : t_presc

    task automatic t_ext();
        logic [2:0] mode [3] = '{3'b000, 3'b100, 3'b001};
        for (int k = 0; k < 3; k++)
        begin
            wr(STC_OFS_CTRL, 8'h00);
            wr(STC_OFS_AUX, {7'h0, mode[k][0]});
            set_count(8'h00, 8'h00);
            wr(STC_OFS_CTRL, {5'b0, mode[k][2], 2'b11});
            far.burst(5, mode[k][0], mode[k][2] ? 3 : 8);
            repeat (10) @(posedge hclk);
            wr(STC_OFS_CTRL, 8'h00);
            rdc("ext count", STC_OFS_LOW, 32'h5);
        end
        $display("test external clock done");
    endtask : t_ext

    // reset in mid-run, with the timer counting and both routes on
    task automatic t_rerun();
        wr(STC_OFS_CTRL, 8'h49);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        check("tb_e in reset", 32'(tb_e), 32'h0);
        hresetn <= 1'b1;
        rdc("ctrl after reset", STC_OFS_CTRL, 32'h0);
        rdc("low after reset", STC_OFS_LOW, 32'h0);
        check("tb_a after reset", 32'(tb_a), 32'h0);
        $display("test mid-run reset done");
    endtask : t_rerun

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 8'h00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        n_errors = 0;
        tests_run = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_wide();
        t_route();
        t_ovf();
        t_presc();
        t_ext();
        t_rerun();
        tally_and_finish();
    end
endmodule : stc_timer_tb

`default_nettype wire
